//--- core/pport_pkg.sv
package pport_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_PIN_EN   = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_PAD      = 8'h08;
  localparam logic [7:0] OFS_CTRL     = 8'h0c;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam logic [7:0] OFS_IN_BUF   = 8'h20;  // Four words, software reads
  localparam logic [7:0] OFS_OUT_BUF  = 8'h30;  // Four words, software writes
  localparam logic [7:0] OFS_BUF_MASK = 8'hf0;

  // Pin enable layout
  localparam int                PEN_SEL      = 14;
  localparam int                PEN_ADDR_HI  = 10;
  localparam int                PEN_ADDR_LO  = 2;
  localparam logic [15:0] PEN_WR_MASK  = 16'h47ff;
  localparam logic [15:0] PEN_RESET    = 16'h0000;

  // Slave buffer status layout
  localparam int ST_IN_ALL_FULL   = 15;
  localparam int ST_IN_OVF        = 14;
  localparam int ST_IN_FULL_LO    = 8;
  localparam int ST_OUT_ALL_EMPTY = 7;
  localparam int ST_OUT_UNF       = 6;
  localparam int ST_OUT_EMPTY_LO  = 0;

  // Pad and control layout
  localparam int PAD_TTL  = 0;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_IRQ_MODE = 2;

  // Interrupt status layout
  localparam int IST_OVF  = 0;
  localparam int IST_UNF  = 1;
  localparam int IST_XFER = 2;
  localparam int IST_W    = 3;

  // Port mode and interrupt request mode codes
  localparam logic [1:0] MODE_LEGACY   = 2'b00;
  localparam logic [1:0] MODE_ENHANCED = 2'b01;
  localparam logic [1:0] IRQ_MODE_NONE = 2'b00;
  localparam logic [1:0] IRQ_MODE_EACH = 2'b01;
  localparam logic [1:0] IRQ_MODE_BUF3 = 2'b11;

  localparam int         BUF_DEPTH = 4;
  localparam logic [1:0] BUF_LAST  = 2'd3;
  localparam logic [1:0] AHB_NONSEQ_BIT = 2'b10;
endpackage : pport_pkg

//--- core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,  // System clock
  input  wire logic         rst_i,  // Synchronous reset
  input  wire logic [W-1:0] d_i,    // Asynchronous pins
  output logic      [W-1:0] q_o     // Synchronised levels
);
  logic [W-1:0] meta_r;

  // Two stages; only the second stage is read outside
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : pin_sync

//--- core/byte_bank.sv
`timescale 1ns/1ps
module byte_bank #(
  parameter int DEPTH = 4,
  parameter int W     = 8,
  parameter int AW    = 2
) (
  input  wire logic             clk_i,         // System clock
  input  wire logic             rst_i,         // Synchronous reset
  input  wire logic             wr_en_i,       // Write strobe
  input  wire logic [AW-1:0]    wr_idx_i,      // Write index
  input  wire logic [W-1:0]     wr_data_i,     // Write byte
  input  wire logic             rd_en_i,       // Read strobe, empties slot
  input  wire logic [AW-1:0]    rd_idx_i,      // Read index
  output logic      [W-1:0]     rd_data_o,     // Byte at read index
  output logic      [DEPTH-1:0] full_o,        // Slot holds unread data
  output logic                  wr_refused_o,  // Write hit a full slot
  output logic                  rd_empty_o     // Read hit an empty slot
);
  logic [W-1:0] mem_r [DEPTH];

  assign rd_data_o    = mem_r[rd_idx_i];
  assign wr_refused_o = wr_en_i && full_o[wr_idx_i];
  assign rd_empty_o   = rd_en_i && !full_o[rd_idx_i];

  // A refused write keeps the unread byte intact
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
    end else if (wr_en_i && !full_o[wr_idx_i]) begin
      mem_r[wr_idx_i] <= wr_data_i;
    end
  end

  // Accepted fill wins over drain on the same slot; a refused fill must not re-arm a drained slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_o <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (wr_en_i && !full_o[i] && wr_idx_i == AW'(i)) full_o[i] <= 1'b1;
        else if (rd_en_i && rd_idx_i == AW'(i)) full_o[i] <= 1'b0;
      end
    end
  end
endmodule : byte_bank

//--- core/pport_status.sv
`timescale 1ns/1ps
// Operation
// - Pin enable bit 14 hands the select pin to the port as address bit 14 or chip select, else it stays I/O.
// - Enable bits 10 to 2 each turn their pin into a port address output, else it stays I/O.
// - Enable bits 1 and 0 give the two lowest pins to the port as address bits or latch strobes.
// - The input-all-full flag is set only while every writable input buffer holds data.
// - A host write into a full input byte sets the overflow flag, which software clears.
// - Each input buffer full flag is set while unread and clears when software reads that buffer.
// - The output-all-empty flag is one while all readable output buffers are empty, also after reset.
// - A host read of an empty output byte sets the underflow flag, which software clears.
// - Each output buffer empty flag is one after reset, clears on a software write, sets when sent.
// - The pad threshold bit selects TTL input buffers when one and Schmitt buffers when zero.
// - Unimplemented status bits read zero and ignore writes.
// - Buffer flags act in slave modes: code 01 addressed enhanced port, code 00 legacy port.
// - Interrupt mode 11 raises the interrupt when buffer 3 is read or written by the host.
module pport_status (
  input  wire logic        CLK_I,          // 250 MHz system clock
  input  wire logic        RST_I,          // Synchronous reset, high
  input  wire logic        HSEL_I,         // AHB slave select
  input  wire logic [31:0] HADDR_I,        // AHB address
  input  wire logic [1:0]  HTRANS_I,       // AHB transfer type
  input  wire logic        HWRITE_I,       // AHB write
  input  wire logic [2:0]  HSIZE_I,        // AHB size, word only
  input  wire logic [31:0] HWDATA_I,       // AHB write data
  input  wire logic        HREADY_I,       // AHB bus ready
  output logic      [31:0] HRDATA_O,       // AHB read data
  output logic             HREADYOUT_O,    // AHB slave ready
  output logic             HRESP_O,        // AHB response, OKAY
  input  wire logic        HOST_CS_I,      // Host chip select, high
  input  wire logic        HOST_RD_I,      // Host read strobe, high
  input  wire logic        HOST_WR_I,      // Host write strobe, high
  input  wire logic [1:0]  HOST_ADDR_I,    // Host buffer address pins
  input  wire logic [7:0]  HOST_DATA_I,    // Host data pins in
  output logic      [7:0]  HOST_DATA_O,    // Host data pins out
  output logic             HOST_DATA_OE_O, // Host data drive enable
  output logic      [15:0] PIN_FUNC_O,     // Per-pin port function select
  output logic             PAD_TTL_O,      // TTL input buffer select
  output logic             IRQ_O           // Level interrupt
);
  localparam int SW = 13;

  logic [15:0]         pen_r;
  logic                pad_r;
  logic [1:0]          mode_r;
  logic [1:0]          irq_mode_r;
  logic                ovf_r;
  logic                unf_r;
  logic [pport_pkg::IST_W-1:0] ist_r;
  logic [pport_pkg::IST_W-1:0] imask_r;
  logic                wr_pend_r;
  logic [7:0]          wr_addr_r;
  logic                rd_lvl_r;
  logic                wr_lvl_r;
  logic [SW-1:0]       pins_s;
  logic                h_cs;
  logic                h_rd;
  logic                h_wr;
  logic [1:0]          h_addr;
  logic [7:0]          h_data;
  logic                slave_on;
  logic [1:0]          h_idx;
  logic                host_wr_ev;
  logic                host_rd_ev;
  logic                ahb_rd;
  logic                ahb_wr;
  logic [7:0]          a_addr;
  logic                in_rd_en;
  logic                out_wr_en;
  logic [7:0]          in_rd_data;
  logic [7:0]          out_rd_data;
  logic [3:0]          in_full;
  logic [3:0]          out_full;
  logic                in_ovf_ev;
  logic                out_unf_ev;
  logic                xfer_ev;
  logic                in_all_full;
  logic                out_all_empty;
  logic [15:0]         status_w;
  logic [pport_pkg::IST_W-1:0] ist_set;

  function automatic logic in_region(input logic [7:0] a, input logic [7:0] base);
    return (a & pport_pkg::OFS_BUF_MASK) == base;
  endfunction : in_region

  // Host pins cross into the clock domain before any use
  pin_sync #(.W(SW)) u_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   ({HOST_CS_I, HOST_RD_I, HOST_WR_I, HOST_ADDR_I, HOST_DATA_I}),
    .q_o   (pins_s)
  );
  assign {h_cs, h_rd, h_wr, h_addr, h_data} = pins_s;

  // Host accesses count only in the two slave modes
  assign slave_on = (mode_r == pport_pkg::MODE_LEGACY) || (mode_r == pport_pkg::MODE_ENHANCED);
  // Legacy port has no address lines; enhanced reads them only where enabled
  assign h_idx = (mode_r == pport_pkg::MODE_ENHANCED) ? (h_addr & pen_r[1:0]) : 2'd0;
  assign host_wr_ev = slave_on && h_cs && h_wr && !wr_lvl_r;
  assign host_rd_ev = slave_on && h_cs && h_rd && !rd_lvl_r;

  // Strobe history for edge detection
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rd_lvl_r <= 1'b0;
      wr_lvl_r <= 1'b0;
    end else begin
      rd_lvl_r <= h_cs && h_rd;
      wr_lvl_r <= h_cs && h_wr;
    end
  end

  // AHB address phase decode; slave is always ready
  assign a_addr = HADDR_I[7:0];
  assign ahb_rd = HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;
  assign ahb_wr = HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I;
  assign in_rd_en  = ahb_rd && in_region(a_addr, pport_pkg::OFS_IN_BUF);
  assign out_wr_en = wr_pend_r && in_region(wr_addr_r, pport_pkg::OFS_OUT_BUF);

  // Host writes fill the input bank, software reads drain it
  byte_bank #(.DEPTH(pport_pkg::BUF_DEPTH)) u_in (
    .clk_i        (CLK_I),
    .rst_i        (RST_I),
    .wr_en_i      (host_wr_ev),
    .wr_idx_i     (h_idx),
    .wr_data_i    (h_data),
    .rd_en_i      (in_rd_en),
    .rd_idx_i     (a_addr[3:2]),
    .rd_data_o    (in_rd_data),
    .full_o       (in_full),
    .wr_refused_o (in_ovf_ev),
    .rd_empty_o   ()
  );

  // Software writes fill the output bank, host reads send it
  byte_bank #(.DEPTH(pport_pkg::BUF_DEPTH)) u_out (
    .clk_i        (CLK_I),
    .rst_i        (RST_I),
    .wr_en_i      (out_wr_en),
    .wr_idx_i     (wr_addr_r[3:2]),
    .wr_data_i    (HWDATA_I[7:0]),
    .rd_en_i      (host_rd_ev),
    .rd_idx_i     (h_idx),
    .rd_data_o    (out_rd_data),
    .full_o       (out_full),
    .wr_refused_o (),
    .rd_empty_o   (out_unf_ev)
  );

  // Aggregate flags; legacy mode has a single writable and readable slot
  assign in_all_full   = (mode_r == pport_pkg::MODE_ENHANCED) ? &in_full : in_full[0];
  assign out_all_empty = (mode_r == pport_pkg::MODE_ENHANCED) ? ~|out_full : !out_full[0];

  // Status word; unimplemented positions stay zero
  always_comb begin
    status_w = '0;
    status_w[pport_pkg::ST_IN_ALL_FULL]   = in_all_full;
    status_w[pport_pkg::ST_IN_OVF]        = ovf_r;
    status_w[pport_pkg::ST_IN_FULL_LO +: 4] = in_full;
    status_w[pport_pkg::ST_OUT_ALL_EMPTY] = out_all_empty;
    status_w[pport_pkg::ST_OUT_UNF]       = unf_r;
    status_w[pport_pkg::ST_OUT_EMPTY_LO +: 4] = ~out_full;
  end

  // Pending write captured in the address phase
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= ahb_wr;
      wr_addr_r <= a_addr;
    end
  end

  // Software configuration registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pen_r   <= pport_pkg::PEN_RESET;
      pad_r   <= 1'b0;
      mode_r  <= pport_pkg::MODE_LEGACY;
      irq_mode_r <= pport_pkg::IRQ_MODE_NONE;
      imask_r <= '0;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        pport_pkg::OFS_PIN_EN: pen_r <= HWDATA_I[15:0] & pport_pkg::PEN_WR_MASK;
        pport_pkg::OFS_PAD: pad_r <= HWDATA_I[pport_pkg::PAD_TTL];
        pport_pkg::OFS_CTRL: begin
          mode_r <= HWDATA_I[pport_pkg::CTRL_MODE +: 2];
          irq_mode_r <= HWDATA_I[pport_pkg::CTRL_IRQ_MODE +: 2];
        end
        pport_pkg::OFS_INT_MASK: imask_r <= HWDATA_I[pport_pkg::IST_W-1:0];
        default: ;
      endcase
    end
  end

  // Error flags: hardware set wins over a software write in the same cycle
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end else begin
      if (in_ovf_ev) ovf_r <= 1'b1;
      else if (wr_pend_r && wr_addr_r == pport_pkg::OFS_STATUS) ovf_r <= HWDATA_I[pport_pkg::ST_IN_OVF];
      if (out_unf_ev) unf_r <= 1'b1;
      else if (wr_pend_r && wr_addr_r == pport_pkg::OFS_STATUS) unf_r <= HWDATA_I[pport_pkg::ST_OUT_UNF];
    end
  end

  // Transfer event per interrupt request mode; stall mode is not modelled
  always_comb begin
    unique case (irq_mode_r)
      pport_pkg::IRQ_MODE_EACH: xfer_ev = host_wr_ev || host_rd_ev;
      pport_pkg::IRQ_MODE_BUF3: xfer_ev = (host_wr_ev || host_rd_ev) && h_idx == pport_pkg::BUF_LAST;
      default:              xfer_ev = 1'b0;
    endcase
  end

  assign ist_set = {xfer_ev, out_unf_ev, in_ovf_ev};

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ist_r <= '0;
    end else if (wr_pend_r && wr_addr_r == pport_pkg::OFS_INT_STAT) begin
      ist_r <= (ist_r & ~HWDATA_I[pport_pkg::IST_W-1:0]) | ist_set;
    end else begin
      ist_r <= ist_r | ist_set;
    end
  end

  // Registered outputs: pin functions, pad select, interrupt
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PIN_FUNC_O <= '0;
      PAD_TTL_O  <= 1'b0;
      IRQ_O      <= 1'b0;
    end else begin
      PIN_FUNC_O <= pen_r;
      PAD_TTL_O  <= pad_r;
      IRQ_O      <= |(ist_r & imask_r);
    end
  end

  // Host data return; drive only while the host holds its read strobe
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      HOST_DATA_O    <= '0;
      HOST_DATA_OE_O <= 1'b0;
    end else begin
      if (host_rd_ev) HOST_DATA_O <= out_rd_data;
      HOST_DATA_OE_O <= slave_on && h_cs && h_rd;
    end
  end

  // AHB read data registered for the data phase; zero-wait OKAY
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      HRDATA_O    <= '0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      if (ahb_rd) begin
        HRDATA_O <= '0;
        if (in_rd_en) HRDATA_O <= {24'h0, in_rd_data};
        else begin
          unique case (a_addr)
            pport_pkg::OFS_PIN_EN:   HRDATA_O <= {16'h0, pen_r};
            pport_pkg::OFS_STATUS:   HRDATA_O <= {16'h0, status_w};
            pport_pkg::OFS_PAD:      HRDATA_O <= {31'h0, pad_r};
            pport_pkg::OFS_CTRL:     HRDATA_O <= {28'h0, irq_mode_r, mode_r};
            pport_pkg::OFS_INT_STAT: HRDATA_O <= {29'h0, ist_r};
            pport_pkg::OFS_INT_MASK: HRDATA_O <= {29'h0, imask_r};
            default: ;
          endcase
        end
      end
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_buf3_hit;
    irq_mode_r == pport_pkg::IRQ_MODE_BUF3 && (host_wr_ev || host_rd_ev) && h_idx == pport_pkg::BUF_LAST;
  endsequence
  sequence s_irq_raise;
    ist_r[pport_pkg::IST_XFER] ##1 (IRQ_O || !imask_r[pport_pkg::IST_XFER]);
  endsequence

  a_select_pin_map: assert property (1'b1 |=> PIN_FUNC_O[pport_pkg::PEN_SEL] == $past(pen_r[pport_pkg::PEN_SEL]))
    else $error("select pin function does not follow its enable");
  a_addr_pin_map: assert property (##1 PIN_FUNC_O[pport_pkg::PEN_ADDR_HI:pport_pkg::PEN_ADDR_LO] == $past(pen_r[pport_pkg::PEN_ADDR_HI:pport_pkg::PEN_ADDR_LO]))
    else $error("address pin functions do not follow enables");
  a_strobe_pin_map: assert property ($changed(pen_r[1:0]) |=> PIN_FUNC_O[1:0] == $past(pen_r[1:0]))
    else $error("strobe pin functions do not follow enables");
  a_all_full_flag: assert property (status_w[pport_pkg::ST_IN_ALL_FULL] |-> in_full[0] && (mode_r != pport_pkg::MODE_ENHANCED || &in_full))
    else $error("input all full set while a buffer is empty");
  a_overflow_sets: assert property (host_wr_ev && in_full[h_idx] |=> ovf_r)
    else $error("overflow flag not set on write to full buffer");
  a_input_read_clears: assert property (in_rd_en && !(host_wr_ev && h_idx == a_addr[3:2]) |=> !in_full[$past(a_addr[3:2])])
    else $error("input full flag not cleared by read");
  a_empty_after_reset: assert property ($past(RST_I) |-> status_w[pport_pkg::ST_OUT_ALL_EMPTY] && status_w[pport_pkg::ST_OUT_EMPTY_LO +: 4] == 4'hf)
    else $error("output empty flags not set after reset");
  a_underflow_sets: assert property (host_rd_ev && !out_full[h_idx] |=> unf_r)
    else $error("underflow flag not set on read of empty buffer");
  a_out_write_clears: assert property (out_wr_en |=> !status_w[$past(wr_addr_r[3:2])])
    else $error("output empty flag not cleared by write");
  a_ttl_select: assert property ($changed(pad_r) |=> PAD_TTL_O == $past(pad_r))
    else $error("pad threshold output does not follow select");
  a_reserved_zero: assert property (status_w[13:12] == 2'b00 && status_w[5:4] == 2'b00)
    else $error("unimplemented status bits not zero");
  a_buf3_irq: assert property (s_buf3_hit |=> s_irq_raise)
    else $error("buffer 3 access did not raise interrupt");
  a_overflow_keeps: assert property (host_wr_ev && in_full[h_idx] |=> u_in.mem_r[$past(h_idx)] == $past(u_in.mem_r[h_idx]))
    else $error("overflowing write altered unread data");
endmodule : pport_status

//--- sim/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_i,  // System clock
  input  wire logic [7:0] dev_i,  // Byte driven by device
  input  wire logic       oe_i,   // Device drive enable
  output logic            cs_o,   // Chip select
  output logic            rd_o,   // Read strobe
  output logic            wr_o,   // Write strobe
  output logic      [1:0] addr_o, // Buffer address
  output logic      [7:0] data_o  // Byte to device
);
  // Idle bus after power-up
  initial begin
    cs_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 2'h0;
    data_o = 8'h00;
  end

  // One strobe; held six cycles and idle four, longer than the synchroniser needs
  task automatic strobe(input logic w, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cs_o <= 1'b1;
    rd_o <= !w;
    wr_o <= w;
    addr_o <= a;
    data_o <= w ? d : ~data_o;
    repeat (6) @(posedge clk_i);
    q = oe_i ? dev_i : 8'hxx;
    cs_o <= 1'b0;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    // Released lines show garbage, never the last value
    addr_o <= ~a;
    data_o <= ~data_o;
    repeat (4) @(posedge clk_i);
  endtask : strobe
endmodule : host_model

//--- sim/parallel_port_buffer_status_pins_test.sv
`timescale 1ns/1ps
module parallel_port_buffer_status_pins_test;
  logic        clk, rst, hsel, hwrite, hready, hresp, irq, oe, ttl;
  logic [1:0]  htrans, haddr_h;
  logic [31:0] haddr, hwdata, hrdata, rv, seed;
  logic [15:0] pfunc;
  logic [7:0]  hdo, hdi, q;
  logic        hcs, hrd, hwr;
  int          err_count, compares, mode, irq_mode, mask;
  logic [7:0]  in_d[4], out_d[4];
  bit          in_f[4], out_e[4];
  bit          input_overflow_flag, output_underflow_flag;
  bit [2:0]    ist;

  pport_status dut (.CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .HOST_CS_I(hcs), .HOST_RD_I(hrd), .HOST_WR_I(hwr),
    .HOST_ADDR_I(haddr_h), .HOST_DATA_I(hdi), .HOST_DATA_O(hdo), .HOST_DATA_OE_O(oe),
    .PIN_FUNC_O(pfunc), .PAD_TTL_O(ttl), .IRQ_O(irq));
  host_model host (.clk_i(clk), .dev_i(hdo), .oe_i(oe), .cs_o(hcs), .rd_o(hrd), .wr_o(hwr),
    .addr_o(haddr_h), .data_o(hdi));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One AHB single transfer; the wait for ready is bounded
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    rv = hrdata;
    if (n >= 40) begin
      err_count++;
      $display("ERROR %0t bus wait ran out", $time);
      give_verdict();
    end
  endtask : ahb

  function automatic logic [31:0] stat_exp;
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < 4; i++) begin
      s[8 + i] = in_f[i];
      s[i] = out_e[i];
    end
    s[15] = (mode == 1) ? (in_f[0] & in_f[1] & in_f[2] & in_f[3]) : in_f[0];
    s[7] = (mode == 1) ? (out_e[0] & out_e[1] & out_e[2] & out_e[3]) : out_e[0];
    s[14] = input_overflow_flag;
    s[6] = output_underflow_flag;
    return s;
  endfunction : stat_exp

  task automatic chk_stat;
    ahb(1'b0, pport_pkg::OFS_STATUS, 32'h0);
    check(rv, stat_exp());
  endtask : chk_stat

  task automatic chk_irq;
    ahb(1'b0, pport_pkg::OFS_INT_STAT, 32'h0);
    check(rv, {29'h0, ist});
    check({31'h0, irq}, {31'h0, |(ist & mask[2:0])});
  endtask : chk_irq

  task automatic ctrl(input int m, input int i);
    mode = m;
    irq_mode = i;
    ahb(1'b1, pport_pkg::OFS_CTRL, 32'(m + 4 * i));
  endtask : ctrl

  // Host write, model updated from the documented slot behaviour
  task automatic hw(input logic [1:0] a, input logic [7:0] d);
    int k;
    k = (mode == 1) ? a : 0;
    host.strobe(1'b1, a, d, q);
    if (mode < 2) begin
      if (in_f[k]) begin
        input_overflow_flag = 1;
        ist[0] = 1'b1;
      end else begin
        in_f[k] = 1;
        in_d[k] = d;
      end
      if (irq_mode == 1 || (irq_mode == 3 && k == 3)) ist[2] = 1'b1;
    end
  endtask : hw

  task automatic hr(input logic [1:0] a);
    int k;
    k = (mode == 1) ? a : 0;
    host.strobe(1'b0, a, 8'h00, q);
    check({24'h0, q}, {24'h0, out_d[k]});
    if (out_e[k]) begin
      output_underflow_flag = 1;
      ist[1] = 1'b1;
    end
    out_e[k] = 1;
    if (irq_mode == 1 || (irq_mode == 3 && k == 3)) ist[2] = 1'b1;
  endtask : hr

  task automatic sw_in(input int k);
    ahb(1'b0, pport_pkg::OFS_IN_BUF + 8'(4 * k), 32'h0);
    check(rv, {24'h0, in_d[k]});
    in_f[k] = 0;
  endtask : sw_in

  // Main sequence
  initial begin
    {hsel, hwrite, rst} = 3'b001;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    seed = 32'h5284;
    mode = 0;
    irq_mode = 0;
    mask = 0;
    for (int i = 0; i < 4; i++) begin
      out_e[i] = 1;
      out_d[i] = 8'h00;
    end
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_stat();
    check({14'h0, pfunc, ttl, irq}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      ahb(1'b1, pport_pkg::OFS_PIN_EN, seed);
      ahb(1'b0, pport_pkg::OFS_PIN_EN, 32'h0);
      check(rv, {16'h0, seed[15:0] & pport_pkg::PEN_WR_MASK});
      check({16'h0, pfunc}, {16'h0, seed[15:0] & pport_pkg::PEN_WR_MASK});
    end
    ahb(1'b1, pport_pkg::OFS_PIN_EN, 32'h47ff);
    // Register loads at the end of the data phase, the output flop one edge later
    repeat (2) @(posedge clk);
    check({16'h0, pfunc}, 32'h47ff);
    for (int b = 0; b < 2; b++) begin
      ahb(1'b1, pport_pkg::OFS_PAD, 32'(b));
      repeat (2) @(posedge clk);
      check({31'h0, ttl}, 32'(b));
    end
    $display("test pins done");
    ctrl(1, 0);
    mask = 7;
    ahb(1'b1, pport_pkg::OFS_INT_MASK, 32'h7);
    // Fill every input slot, then hit a full one
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      hw(2'(k), seed[7:0]);
      chk_stat();
    end
    hw(2'h2, 8'h5a);
    chk_stat();
    chk_irq();
    for (int k = 0; k < 4; k++) sw_in(k);
    chk_stat();
    ahb(1'b1, pport_pkg::OFS_STATUS, 32'hffffffff);
    {input_overflow_flag, output_underflow_flag} = 2'b11;
    chk_stat();
    ahb(1'b1, pport_pkg::OFS_STATUS, 32'h0);
    {input_overflow_flag, output_underflow_flag} = 2'b00;
    ahb(1'b1, pport_pkg::OFS_INT_STAT, 32'h7);
    ist = 3'h0;
    chk_irq();
    $display("test input done");
    // Output slots filled by software, drained by host
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      ahb(1'b1, pport_pkg::OFS_OUT_BUF + 8'(4 * k), {24'h0, seed[7:0]});
      out_d[k] = seed[7:0];
      out_e[k] = 0;
      chk_stat();
    end
    ctrl(1, 3);
    for (int k = 0; k < 4; k++) begin
      hr(2'(k));
      chk_irq();
    end
    chk_stat();
    hr(2'h1);
    chk_stat();
    chk_irq();
    mask = 0;
    ahb(1'b1, pport_pkg::OFS_INT_MASK, 32'h0);
    chk_irq();
    mask = 7;
    ahb(1'b1, pport_pkg::OFS_INT_MASK, 32'h7);
    ahb(1'b1, pport_pkg::OFS_INT_STAT, 32'h7);
    {ist, output_underflow_flag} = 4'h0;
    ahb(1'b1, pport_pkg::OFS_STATUS, 32'h0);
    ctrl(1, 1);
    hw(2'h1, 8'hc3);
    chk_irq();
    $display("test output done");
    // Legacy and master codes
    // Stall code in legacy mode must raise no transfer interrupt
    ctrl(0, 2);
    ahb(1'b1, pport_pkg::OFS_INT_STAT, 32'h7);
    ist = 3'h0;
    sw_in(1);
    hw(2'h3, 8'h96);
    chk_stat();
    chk_irq();
    ctrl(2, 0);
    hw(2'h0, 8'h69);
    chk_stat();
    ahb(1'b1, 8'h1c, 32'hffffffff);
    ahb(1'b0, 8'h1c, 32'h0);
    check(rv, 32'h0);
    check({31'h0, hresp}, 32'h0);
    $display("test modes done");
    give_verdict();
  end
endmodule : parallel_port_buffer_status_pins_test
